/* shared/dtsr_pkg.sv */
// Purpose: Shared constants and types of the debug test signal router.
// Assumes: APB registers sit at four times their register index.
// Notes: Reset values of the configuration bytes are all zero.
package dtsr_pkg;

    // Register indices and the APB byte addresses derived from them.
    localparam logic [7:0] IDX_BUS_ON = 8'h17;
    localparam logic [7:0] IDX_KIND = 8'hf0;
    localparam logic [7:0] IDX_PAD_COUNT = 8'hf3;
    localparam logic [7:0] IDX_PAD_MAP = 8'hf4;
    localparam logic [7:0] IDX_DAC_A = 8'hf8;
    localparam logic [7:0] IDX_DAC_B = 8'hf9;
    localparam logic [7:0] IDX_CMD = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [11:0] ADDR_BUS_ON = {2'b00, IDX_BUS_ON, 2'b00};
    localparam logic [11:0] ADDR_KIND = {2'b00, IDX_KIND, 2'b00};
    localparam logic [11:0] ADDR_PAD_COUNT = {2'b00, IDX_PAD_COUNT, 2'b00};
    localparam logic [11:0] ADDR_PAD_MAP = {2'b00, IDX_PAD_MAP, 2'b00};
    localparam logic [11:0] ADDR_DAC_A = {2'b00, IDX_DAC_A, 2'b00};
    localparam logic [11:0] ADDR_DAC_B = {2'b00, IDX_DAC_B, 2'b00};
    localparam logic [11:0] ADDR_CMD = {2'b00, IDX_CMD, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

    // Reset values.
    localparam logic RST_BUS_ON = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_PAD_MAP = 32'h0000_0000;

    // Field positions of the command word.
    localparam int CMD_GROUP_LSB = 0;
    localparam int CMD_CODE_LSB = 8;
    localparam int CMD_PIN_LSB = 12;
    localparam int CMD_CLEAR_BIT = 16;

    // Probe kinds.
    localparam logic [7:0] KIND_ANALOG = 8'h01;
    localparam logic [7:0] KIND_DIGITAL = 8'h02;

    // Signal group codes.
    localparam logic [7:0] GRP_CLOCK = 8'h01;
    localparam logic [7:0] GRP_TX_ENC = 8'h1b;
    localparam logic [7:0] GRP_TIMER = 8'h1d;
    localparam logic [7:0] GRP_CARD = 8'h30;
    localparam logic [7:0] GRP_XCV = 8'h58;
    localparam logic [7:0] GRP_RX_DATA = 8'h70;
    localparam logic [7:0] GRP_RX_ERR = 8'h73;
    localparam logic [3:0] CODE_CLK13 = 4'h8;

    // Physical pin numbering of the router outputs.
    localparam int NUM_PINS = 5;
    localparam int NUM_CMD_PINS = 4;
    localparam int NUM_PAD_ENTRIES = 4;
    localparam int MAX_DIGITAL = 4;
    localparam logic [2:0] PIN_IRQ = 3'h0;
    localparam logic [2:0] PIN_GPO = 3'h1;
    localparam logic [2:0] PIN_AUX_B = 3'h2;
    localparam logic [2:0] PIN_AUX_A = 3'h3;
    localparam logic [2:0] PIN_DWL = 3'h4;

    // Pad location codes of a pad route entry.
    localparam logic [3:0] PAD_IRQ = 4'h0;
    localparam logic [3:0] PAD_AUX_B = 4'h1;
    localparam logic [3:0] PAD_DWL = 4'h2;
    localparam logic [3:0] PAD_AUX_A = 4'h3;

    // Internal signals offered to the router.
    typedef struct packed {
        logic clk_13m56;
        logic [7:0] clk_grp;
        logic tx_env;
        logic tx_irq;
        logic [2:0] tmr_run;
        logic [2:0] tmr_exp;
        logic [7:0] card_grp;
        logic [7:0] xcv_grp;
        logic [7:0] rxd_grp;
        logic [7:0] rxe_grp;
    } dtsr_src_t;

    // One digital route held per command pin.
    typedef struct packed {
        logic on;
        logic [7:0] group;
        logic [3:0] code;
    } dtsr_route_t;

endpackage : dtsr_pkg

/* logic/dtsr_sig_select.sv */
// Purpose: Decodes a signal group and code into one probe bit and the group's test bus.
// Assumes: All sources run on the router clock.
// Notes: Purely combinational.
`timescale 1ns/1ps
module dtsr_sig_select (
    input wire dtsr_pkg::dtsr_src_t src, // Internal signals.
    input wire logic [7:0] group, // Group code.
    input wire logic [3:0] code, // Signal code.
    output logic [7:0] test_bus, // Eight signals of the group.
    output logic sig // Selected signal.
);

    logic known;

    // Builds the group bus; reserved positions read low.
    always_comb begin
        known = 1'b1;
        case (group)
            dtsr_pkg::GRP_CLOCK: test_bus = src.clk_grp;
            dtsr_pkg::GRP_TX_ENC: test_bus = {6'h00, src.tx_env, src.tx_irq};
            dtsr_pkg::GRP_TIMER: test_bus = {src.tmr_run[0], src.tmr_exp[0], src.tmr_run[1], src.tmr_exp[1],
                                             src.tmr_run[2], src.tmr_exp[2], 2'b00};
            dtsr_pkg::GRP_CARD: test_bus = src.card_grp;
            dtsr_pkg::GRP_XCV: test_bus = src.xcv_grp;
            dtsr_pkg::GRP_RX_DATA: test_bus = src.rxd_grp;
            dtsr_pkg::GRP_RX_ERR: test_bus = {src.rxe_grp[7:6], 3'b000, src.rxe_grp[2:0]};
            default: begin
                test_bus = 8'h00;
                known = 1'b0;
            end
        endcase
    end

    // Codes 0 to 7 pick a bit, code 8 the 13.56 MHz clock; an unknown group or any other code stays low.
    always_comb begin
        if (!known) begin
            sig = 1'b0;
        end else if (code == dtsr_pkg::CODE_CLK13) begin
            sig = src.clk_13m56;
        end else if (!code[3]) begin
            sig = test_bus[code[2:0]];
        end else begin
            sig = 1'b0;
        end
    end

endmodule : dtsr_sig_select

/* logic/dtsr_dac_probe.sv */
// Purpose: Picks one signal processing sample for an analog probe DAC.
// Assumes: Samples run on the router clock and are updated every cycle.
// Notes: The code reaches the DAC one cycle after the sample.
`timescale 1ns/1ps
module dtsr_dac_probe (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic enable, // Analog probing active.
    input wire logic [7:0] source, // Source selection byte.
    input wire logic [15:0][7:0] samples, // Signal processing samples.
    output logic [7:0] dac_code, // Code for the DAC.
    output logic dac_on // DAC drives its pin.
);

    logic valid;

    // Only the documented source numbers produce a probe.
    always_comb begin
        case (source)
            8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a: valid = 1'b1;
            default: valid = 1'b0;
        endcase
    end

    // Registers the chosen sample every cycle, giving a real-time trace.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= 8'h00;
            dac_on <= 1'b0;
        end else begin
            dac_on <= enable && valid;
            dac_code <= (enable && valid) ? samples[source[3:0]] : 8'h00;
        end
    end

endmodule : dtsr_dac_probe

/* logic/dtsr_router.sv */
// Purpose: APB-controlled router of internal signals onto debug pins and DACs.
// Assumes: All probed signals are synchronous to pclk.
// Notes: Pin outputs are override requests; the pad logic muxes them in.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

module dtsr_router (
    input wire logic pclk, // Clock, 50 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.

    input wire dtsr_pkg::dtsr_src_t src, // Internal digital signals.
    input wire logic [15:0][7:0] samples, // Signal processing samples.

    output logic [4:0] pin_drive, // Per pin probe override enable.
    output logic [4:0] pin_level, // Per pin probe level.
    output logic [7:0] dac_a_code, // DAC a code, on the interrupt pin.
    output logic dac_a_on, // DAC a drives the interrupt pin.
    output logic [7:0] dac_b_code, // DAC b code, on aux b.
    output logic dac_b_on // DAC b drives aux b.
);

    logic probe_bus_on;
    logic [7:0] probe_kind_select;
    logic [7:0] pad_route_count;
    logic [31:0] pad_route_map;
    logic [7:0] analog_probe_a_source;
    logic [7:0] analog_probe_b_source;

    logic [15:0] last_cmd;
    logic cmd_rejected;

    logic [7:0] tb_group;
    dtsr_pkg::dtsr_route_t route [dtsr_pkg::NUM_CMD_PINS];

    logic [dtsr_pkg::NUM_CMD_PINS-1:0] cmd_sig;
    logic [7:0] test_bus;
    logic [4:0] pad_on;
    logic [4:0] pad_val;

    logic [4:0] next_drive;
    logic [4:0] next_level;

    logic digital_on;
    logic analog_on;

    logic setup;
    logic access;
    logic wr;
    logic hit;

    logic [31:0] next_rdata;
    logic [3:0] cmd_pin;

    // Probe kind decode, gated by the global enable.
    assign digital_on = probe_bus_on && (probe_kind_select == dtsr_pkg::KIND_DIGITAL);
    assign analog_on = probe_bus_on && (probe_kind_select == dtsr_pkg::KIND_ANALOG);

    // APB phases; the slave answers in the first access cycle.
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && hit;

    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign cmd_pin = pwdata[dtsr_pkg::CMD_PIN_LSB +: 4];

    // Address decode.
    always_comb begin
        case (paddr)
            dtsr_pkg::ADDR_BUS_ON, dtsr_pkg::ADDR_KIND, dtsr_pkg::ADDR_PAD_COUNT, dtsr_pkg::ADDR_PAD_MAP,
            dtsr_pkg::ADDR_DAC_A, dtsr_pkg::ADDR_DAC_B, dtsr_pkg::ADDR_CMD, dtsr_pkg::ADDR_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read data chosen from the current register state.
    always_comb begin
        case (paddr)
            dtsr_pkg::ADDR_BUS_ON: next_rdata = {31'h0000_0000, probe_bus_on};
            dtsr_pkg::ADDR_KIND: next_rdata = {24'h00_0000, probe_kind_select};
            dtsr_pkg::ADDR_PAD_COUNT: next_rdata = {24'h00_0000, pad_route_count};
            dtsr_pkg::ADDR_PAD_MAP: next_rdata = pad_route_map;
            dtsr_pkg::ADDR_DAC_A: next_rdata = {24'h00_0000, analog_probe_a_source};
            dtsr_pkg::ADDR_DAC_B: next_rdata = {24'h00_0000, analog_probe_b_source};
            dtsr_pkg::ADDR_CMD: next_rdata = {16'h0000, last_cmd};
            dtsr_pkg::ADDR_STATUS: next_rdata = {22'h00_0000, dac_b_on, dac_a_on, analog_on, digital_on,
                                                 cmd_rejected, pin_drive};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            probe_bus_on <= dtsr_pkg::RST_BUS_ON;
            probe_kind_select <= dtsr_pkg::RST_BYTE;
            pad_route_count <= dtsr_pkg::RST_BYTE;
            pad_route_map <= dtsr_pkg::RST_PAD_MAP;
            analog_probe_a_source <= dtsr_pkg::RST_BYTE;
            analog_probe_b_source <= dtsr_pkg::RST_BYTE;
        end else if (wr) begin
            case (paddr)
                dtsr_pkg::ADDR_BUS_ON: probe_bus_on <= pwdata[0];
                dtsr_pkg::ADDR_KIND: probe_kind_select <= pwdata[7:0];
                dtsr_pkg::ADDR_PAD_COUNT: pad_route_count <= pwdata[7:0];
                dtsr_pkg::ADDR_PAD_MAP: pad_route_map <= pwdata;
                dtsr_pkg::ADDR_DAC_A: analog_probe_a_source <= pwdata[7:0];
                dtsr_pkg::ADDR_DAC_B: analog_probe_b_source <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Digital probe command: group byte, then signal code and pin nibbles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cmd <= 16'h0000;
            cmd_rejected <= 1'b0;
            tb_group <= 8'h00;

            for (int p = 0; p < dtsr_pkg::NUM_CMD_PINS; p++) begin
                route[p] <= '0;
            end
        end else if (wr && paddr == dtsr_pkg::ADDR_CMD) begin
            if (pwdata[dtsr_pkg::CMD_CLEAR_BIT]) begin
                for (int p = 0; p < dtsr_pkg::NUM_CMD_PINS; p++) begin
                    route[p] <= '0;
                end
            end else if (cmd_pin < 4'(dtsr_pkg::NUM_CMD_PINS)) begin
                last_cmd <= pwdata[15:0];
                cmd_rejected <= 1'b0;
                tb_group <= pwdata[dtsr_pkg::CMD_GROUP_LSB +: 8];
                route[cmd_pin[1:0]] <= {1'b1, pwdata[dtsr_pkg::CMD_GROUP_LSB +: 8],
                                        pwdata[dtsr_pkg::CMD_CODE_LSB +: 4]};
            end else begin
                cmd_rejected <= 1'b1;
            end
        end
    end

    // One selector per command pin.
    generate
        for (genvar p = 0; p < dtsr_pkg::NUM_CMD_PINS; p++) begin : g_cmd
            dtsr_sig_select u_sel (
                .src(src),
                .group(route[p].group),
                .code(route[p].code),
                .test_bus(),
                .sig(cmd_sig[p])
            );
        end
    endgenerate

    // Test bus of the last commanded group feeds the pad routes.
    dtsr_sig_select u_tb_sel (
        .src(src),
        .group(tb_group),
        .code(4'h0),
        .test_bus(test_bus),
        .sig()
    );

    // Applies the first pad route count entries of the pad map.
    always_comb begin
        logic [3:0] pad;
        logic [3:0] bit_sel;
        logic lvl;

        pad = 4'h0;
        bit_sel = 4'h0;
        lvl = 1'b0;

        pad_on = 5'b0_0000;
        pad_val = 5'b0_0000;

        for (int e = 0; e < dtsr_pkg::NUM_PAD_ENTRIES; e++) begin
            if (8'(e) < pad_route_count) begin
                pad = pad_route_map[8*e+4 +: 4];
                bit_sel = pad_route_map[8*e +: 4];

                if (bit_sel == dtsr_pkg::CODE_CLK13) begin
                    lvl = src.clk_13m56;
                end else if (!bit_sel[3]) begin
                    lvl = test_bus[bit_sel[2:0]];
                end else begin
                    lvl = 1'b0;
                end

                case (pad)
                    dtsr_pkg::PAD_IRQ: begin
                        pad_on[dtsr_pkg::PIN_IRQ] = 1'b1;
                        pad_val[dtsr_pkg::PIN_IRQ] = lvl;
                    end

                    dtsr_pkg::PAD_AUX_B: begin
                        pad_on[dtsr_pkg::PIN_AUX_B] = 1'b1;
                        pad_val[dtsr_pkg::PIN_AUX_B] = lvl;
                    end

                    dtsr_pkg::PAD_DWL: begin
                        pad_on[dtsr_pkg::PIN_DWL] = 1'b1;
                        pad_val[dtsr_pkg::PIN_DWL] = lvl;
                    end

                    dtsr_pkg::PAD_AUX_A: begin
                        pad_on[dtsr_pkg::PIN_AUX_A] = 1'b1;
                        pad_val[dtsr_pkg::PIN_AUX_A] = lvl;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Merges command and pad routes; command routes win on a shared pin.
    always_comb begin
        next_drive = 5'b0_0000;
        next_level = 5'b0_0000;

        if (digital_on) begin
            for (int p = 0; p < dtsr_pkg::NUM_CMD_PINS; p++) begin
                if (route[p].on) begin
                    next_drive[p] = 1'b1;
                    next_level[p] = cmd_sig[p];
                end else begin
                    next_drive[p] = pad_on[p];
                    next_level[p] = pad_val[p];
                end
            end

            // The download request pin is only used while fewer than four pins probe.
            if (pad_on[dtsr_pkg::PIN_DWL] && (next_drive[3:0] != 4'hf)) begin
                next_drive[dtsr_pkg::PIN_DWL] = 1'b1;
                next_level[dtsr_pkg::PIN_DWL] = pad_val[dtsr_pkg::PIN_DWL];
            end
        end
    end

    // Pin outputs come from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_drive <= 5'b0_0000;
            pin_level <= 5'b0_0000;
        end else begin
            pin_drive <= next_drive;
            pin_level <= next_level;
        end
    end

    // DAC a sits on the interrupt pin and DAC b on aux b.
    dtsr_dac_probe u_dac_a (
        .pclk(pclk),
        .presetn(presetn),
        .enable(analog_on),
        .source(analog_probe_a_source),
        .samples(samples),
        .dac_code(dac_a_code),
        .dac_on(dac_a_on)
    );

    dtsr_dac_probe u_dac_b (
        .pclk(pclk),
        .presetn(presetn),
        .enable(analog_on),
        .source(analog_probe_b_source),
        .samples(samples),
        .dac_code(dac_b_code),
        .dac_on(dac_b_on)
    );

endmodule : dtsr_router

/* tb/dtsr_router_sva.sv */
// Purpose: Checker of the probe router outputs against the probe bus and kind settings.
// Assumes: Outputs lag the live configuration by one clock.
// Notes: Bound to every router instance.
`timescale 1ns/1ps
module dtsr_router_sva (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Direction.
    input wire logic [11:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic pready, // Ready.
    input wire logic [4:0] pin_drive, // Pin enables.
    input wire logic [4:0] pin_level, // Pin levels.
    input wire logic dac_a_on, // DAC a on.
    input wire logic dac_b_on // DAC b on.
);
    logic on_q; // Shadow of the probe bus enable.
    logic [7:0] kind_q; // Shadow of the probe kind.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadows follow completed APB writes to the two gating bytes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q <= 1'b0;
            kind_q <= 8'h00;
        end else if (psel && penable && pwrite && pready) begin
            if (paddr == dtsr_pkg::ADDR_BUS_ON) begin
                on_q <= pwdata[0];
            end
            if (paddr == dtsr_pkg::ADDR_KIND) begin
                kind_q <= pwdata[7:0];
            end
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence kind_off_s;
        psel && penable && pwrite && paddr == dtsr_pkg::ADDR_KIND && pwdata[7:0] != dtsr_pkg::KIND_ANALOG;
    endsequence
    bus_gate_a: assert property ((pin_drive != 5'h00 || dac_a_on || dac_b_on) |-> $past(on_q))
        else $error("probe active with bus off");
    digital_kind_a: assert property (pin_drive != 5'h00 |-> $past(kind_q) == dtsr_pkg::KIND_DIGITAL)
        else $error("pin driven outside digital kind");
    analog_kind_a: assert property ((dac_a_on || dac_b_on) |-> $past(kind_q) == dtsr_pkg::KIND_ANALOG)
        else $error("dac on outside analog kind");
    kind_leave_a: assert property (kind_off_s |-> ##2 (!dac_a_on && !dac_b_on))
        else $error("dac stays on after kind change");
    probe_count_a: assert property ($countones(pin_drive) <= dtsr_pkg::MAX_DIGITAL)
        else $error("too many digital probes");
    download_limit_a: assert property (pin_drive[4] |-> pin_drive[3:0] != 4'hf)
        else $error("fifth pin driven");
    idle_low_a: assert property ((pin_level & ~pin_drive) == 5'h00)
        else $error("level on undriven pin");
    ready_a: assert property (setup_s |=> pready)
        else $error("access phase not ready");
endmodule : dtsr_router_sva

bind dtsr_router dtsr_router_sva chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pin_drive(pin_drive), .pin_level(pin_level),
    .dac_a_on(dac_a_on), .dac_b_on(dac_b_on)
);

/* tb/dtsr_host.sv */
// Purpose: Host model issuing register and probe commands over APB.
// Assumes: Zero or more wait states; the wait ends on pready.
// Notes: Last read word and error flag are kept for the bench.
`timescale 1ns/1ps
module dtsr_host (
    input wire logic pclk, // Clock.
    output logic psel, // Select.
    output logic penable, // Enable.
    output logic pwrite, // Direction.
    output logic [11:0] paddr, // Address.
    output logic [31:0] pwdata, // Write data.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr // Error.
);
    logic [31:0] rdata; // Last read word.
    logic rerr; // Last error flag.
    // Bus idles with no request.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // One transfer; the request stands until pready is sampled high.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Probe command: group byte, then a byte of pin and signal code.
    task cmd(input logic [7:0] g, input logic [7:0] p2, input logic clr);
        xfer(1'b1, dtsr_pkg::ADDR_CMD, {15'h0000, clr, p2, g});
    endtask : cmd
endmodule : dtsr_host

/* tb/dtsr_router_tb.sv */
// Purpose: Self-checking bench of the probe router.
// Assumes: Outputs settle within four clocks of a change.
// Notes: Expected values queue up; a monitor compares them on falling edges.
`timescale 1ns/1ps
module dtsr_router_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dac_a_on, dac_b_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    dtsr_pkg::dtsr_src_t src;
    logic [15:0][7:0] samples;
    logic [4:0] pin_drive, pin_level;
    logic [7:0] dac_a_code, dac_b_code;
    logic [3:0] p;
    int n_errors, n_compared;
    int w_q[$];
    logic [31:0] e_q[$];
    logic [7:0] grp [8] = '{8'h55, 8'h1b, 8'h1d, 8'h30, 8'h58, 8'h70, 8'h73, 8'h01}; // Clocks last, for the pad test.
    logic [11:0] ra [6] = '{12'h05c, 12'h3c0, 12'h3cc, 12'h3d0, 12'h3e0, 12'h3e4};
    dtsr_router dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
        .samples(samples), .pin_drive(pin_drive), .pin_level(pin_level), .dac_a_code(dac_a_code),
        .dac_a_on(dac_a_on), .dac_b_code(dac_b_code), .dac_b_on(dac_b_on));
    dtsr_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Free running clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Expected level of a group and code, from the source signals.
    function logic lvl(input logic [7:0] g, input logic [3:0] c);
        if (c > 4'h8 || !(g inside {8'h01, 8'h1b, 8'h1d, 8'h30, 8'h58, 8'h70, 8'h73})) return 1'b0;
        if (c == 4'h8) return src.clk_13m56;
        case (g)
            8'h01: return src.clk_grp[c];
            8'h1b: return c == 4'h1 ? src.tx_env : (c == 4'h0 ? src.tx_irq : 1'b0);
            8'h1d: return c < 4'h2 ? 1'b0 : (c[0] ? src.tmr_run[(7 - c) / 2] : src.tmr_exp[(6 - c) / 2]);
            8'h30: return src.card_grp[c];
            8'h58: return src.xcv_grp[c];
            8'h70: return src.rxd_grp[c];
            8'h73: return (c > 4'h2 && c < 4'h6) ? 1'b0 : src.rxe_grp[c];
            default: return 1'b0;
        endcase
    endfunction : lvl
    // Observed value of an output selector.
    function logic [31:0] obs(input int w);
        if (w < 5) return 32'(pin_drive[w]);
        if (w < 10) return 32'(pin_level[w - 5]);
        case (w)
            10: return 32'(dac_a_code);
            11: return 32'(dac_a_on);
            12: return 32'(dac_b_code);
            13: return 32'(dac_b_on);
            14: return host.rdata;
            15: return 32'(host.rerr);
            default: return 32'(host.rdata[5]);
        endcase
    endfunction : obs
    task check(input int w, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] output %0d exp %h seen %h", w, exp, seen);
        end
    endtask : check
    task note(input int w, input logic [31:0] e);
        w_q.push_back(w);
        e_q.push_back(e);
    endtask : note
    task drain;
        while (w_q.size() != 0) @(posedge pclk);
    endtask : drain
    // New random sources, then time for the outputs to follow.
    task settle;
        @(posedge pclk);
        src <= $bits(src)'({$urandom(), $urandom()});
        samples <= {$urandom(), $urandom(), $urandom(), $urandom()};
        repeat (4) @(posedge pclk);
    endtask : settle
    task rd(input logic [11:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0000_0000);
        note(14, e);
        drain();
    endtask : rd
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // Monitor takes the oldest note each falling edge.
    initial begin
        forever begin
            @(negedge pclk);
            if (w_q.size() != 0) begin
                check(w_q[0], obs(w_q[0]), e_q[0]);
                void'(w_q.pop_front());
                void'(e_q.pop_front());
            end
        end
    end
    // Watchdog.
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end
    // Main sequence.
    initial begin
        presetn = 1'b0;
        src = '0;
        samples = '0;
        void'($urandom(32'h70e0));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], 32'h0000_0000);
            d = $urandom();
            host.xfer(1'b1, ra[i], d);
            rd(ra[i], i == 3 ? d : (i == 0 ? d & 32'h0000_0001 : d & 32'h0000_00ff));
        end
        host.xfer(1'b0, 12'h800, 32'h0000_0000);
        note(14, 32'h0000_0000);
        note(15, 32'h0000_0001);
        drain();
        $display("test 1 done");
        host.xfer(1'b1, dtsr_pkg::ADDR_BUS_ON, 32'h0000_0000);
        host.xfer(1'b1, dtsr_pkg::ADDR_KIND, 32'h0000_0002);
        host.xfer(1'b1, dtsr_pkg::ADDR_PAD_COUNT, 32'h0000_0000);
        host.cmd(8'h01, 8'h08, 1'b0);
        settle();
        note(0, 32'h0000_0000);
        drain();
        $display("test 2 done");
        host.xfer(1'b1, dtsr_pkg::ADDR_BUS_ON, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            for (int c = 0; c < 16; c++) begin
                p = 4'($urandom_range(3, 0));
                host.cmd(grp[i], {p, 4'(c)}, 1'b0);
                settle();
                note(p, 32'h0000_0001);
                note(5 + p, 32'(lvl(grp[i], 4'(c))));
                drain();
            end
        end
        host.cmd(8'h01, 8'h48, 1'b0);
        host.xfer(1'b0, dtsr_pkg::ADDR_STATUS, 32'h0000_0000);
        note(16, 32'h0000_0001);
        drain();
        $display("test 3 done");
        host.cmd(8'h01, 8'h00, 1'b1);
        host.xfer(1'b1, dtsr_pkg::ADDR_PAD_MAP, 32'h0028_1238);
        host.xfer(1'b1, dtsr_pkg::ADDR_PAD_COUNT, 32'h0000_0001);
        settle();
        note(3, 32'h0000_0001);
        note(8, 32'(src.clk_13m56));
        note(2, 32'h0000_0000);
        drain();
        host.xfer(1'b1, dtsr_pkg::ADDR_PAD_COUNT, 32'h0000_0003);
        settle();
        note(2, 32'h0000_0001);
        note(7, 32'(src.clk_grp[2]));
        note(4, 32'h0000_0001);
        note(9, 32'(src.clk_13m56));
        drain();
        $display("test 4 done");
        host.xfer(1'b1, dtsr_pkg::ADDR_KIND, 32'h0000_0001);
        host.xfer(1'b1, dtsr_pkg::ADDR_DAC_A, 32'h0000_0001);
        host.xfer(1'b1, dtsr_pkg::ADDR_DAC_B, 32'h0000_000a);
        settle();
        note(11, 32'h0000_0001);
        note(10, 32'(samples[1]));
        note(13, 32'h0000_0001);
        note(12, 32'(samples[10]));
        note(3, 32'h0000_0000);
        drain();
        host.xfer(1'b1, dtsr_pkg::ADDR_DAC_A, 32'h0000_0008);
        host.xfer(1'b1, dtsr_pkg::ADDR_BUS_ON, 32'h0000_0000);
        settle();
        note(11, 32'h0000_0000);
        note(13, 32'h0000_0000);
        drain();
        $display("test 5 done");
        finish_test();
    end
endmodule : dtsr_router_tb
